// ==== rtl/module_power_state_manager.sv ====
/*
 * Power state manager: Active, Sleep, deepest sleep state and Off.
 * Assumes configuration, network status and sleep conditions are on
 * core_clk; the switch-on request, terminal-ready and wake pins are not.
 */
// What this block does
// R01: Four power states; functions adjust per transition.
// R02: Active runs core in one sub-mode.
// R03: Sleep suspends core, keeps watching wake triggers.
// R04: Sleep entry gated by USB, terminal, locks.
// R05: Deepest state only via two modes; core off.
// R06: Stay deepest until wake; then full reboot.
// R07: Configure mode selection and wake sources.
// R08: Deepest state has no own time limit.
// R09: Standalone mode detaches first, then deepest state.
// R10: After standalone wake reattach, stay Active.
// R11: Outside pins tri-stated during standalone sleep; block has no pin outputs to tri-state.
// R12: Network mode keeps context, sleeps negotiated period.
// R13: Network-mode wake boots, then sends update.
// R14: Stay active until inactivity expires, repeat.
// R15: Wake configuration retained, changeable when active.
// R16: Power-up goes Active or deepest per request.
// R17: Network wake timer shorter than update timer.
// R18: Many wakes give one reboot only.
`timescale 1ns/1ps
module module_power_state_manager
	import pwr_pkg::*;
#(
	parameter int unsigned BOOT_CYCLES = BOOT_CYC
) (
	// Clock and reset.
	input  wire logic              core_clk,
	input  wire logic              arst_n,
	// Asynchronous pins.
	input  wire logic              power_on_req_n,
	input  wire logic              term_ready,
	input  wire logic [WAKE_W-1:0] wake_pins,
	// Application side.
	input  wire app_cfg_t          app_cfg,
	input  wire sleep_cond_t       sleep_cond,
	// Network side.
	input  wire net_status_t       net,
	input  wire logic [23:0]       tau_cycles,
	input  wire logic [23:0]       inactive_cycles,
	// Status.
	output pwr_status_t            status
);
	// Whole state of the block in one word.
	typedef struct packed {
		fsm_t              fsm;
		logic              pon_s1;
		logic              pon_s2;
		logic              trdy_s1;
		logic              trdy_s2;
		logic [WAKE_W-1:0] wake_s1;
		logic [WAKE_W-1:0] wake_s2;
		deep_mode_t        mode;
		logic [3:0]        wake_mask;
		logic [23:0]       wake_time;
		logic              net_mode;
		logic [23:0]       cnt;
		pwr_status_t       out;
	} state_t;

	state_t st_reg;    // Registered state.
	state_t st_next;   // Next state.
	logic   sleep_ok;  // Every Sleep condition agrees.
	logic   wake_hit;  // A masked wake pin fires.
	logic   use_net;   // Entry request resolves to network mode.
	logic   use_alone; // Entry request resolves to standalone mode.
	logic [23:0] deep_limit; // Deepest-state wake timer target.
	logic [23:0] boot_lim;   // Boot wait as a counter value.

	assign boot_lim = 24'(BOOT_CYCLES);

	// Combinational helpers derived from the registered state and the inputs.
	always_comb begin
		// USB must be suspended if attached; terminal not ready. [R04]
		sleep_ok = (!sleep_cond.usb_attached || sleep_cond.usb_suspended)
			&& !st_reg.trdy_s2 && !sleep_cond.wake_lock_held
			&& !sleep_cond.gpio_hold && !sleep_cond.ctrl_hold;
		wake_hit = |(st_reg.wake_s2 & st_reg.wake_mask);
		// Fallback uses standalone when the network refuses. [R07]
		use_net = (st_reg.mode == MODE_NETWORK
			|| st_reg.mode == MODE_NET_FALLBK) && net.saving_supported;
		use_alone = st_reg.mode == MODE_STANDALONE
			|| (st_reg.mode == MODE_NET_FALLBK && !net.saving_supported);
		// Timer ends early enough for boot before the update. [R17]
		if (tau_cycles > boot_lim + TAU_GUARD_CYC) begin
			deep_limit = tau_cycles - boot_lim - TAU_GUARD_CYC;
		end else begin
			deep_limit = 24'h000001;
		end
	end

	// Next-state logic for the whole block.
	always_comb begin
		st_next = st_reg;
		// Two-flop synchronisers on every pin input.
		st_next.pon_s1 = power_on_req_n;
		st_next.pon_s2 = st_reg.pon_s1;
		st_next.trdy_s1 = term_ready;
		st_next.trdy_s2 = st_reg.trdy_s1;
		st_next.wake_s1 = wake_pins;
		st_next.wake_s2 = st_reg.wake_s1;
		// Update request and reboot mark last one cycle.
		st_next.out.tau_send = 1'b0;
		st_next.out.rebooted = 1'b0;
		case (st_reg.fsm)
			S_OFF: begin
				// Wait for the strap synchroniser to fill.
				st_next.cnt = st_reg.cnt + 24'h000001;
				if (st_reg.cnt >= SETTLE_CYC) begin
					st_next.cnt = 24'h000000;
					if (!st_reg.pon_s2) begin
						st_next.fsm = S_BOOT; // [R16]
					end else begin
						st_next.fsm = S_DEEP; // [R16]
						st_next.out.state = PWR_DEEP;
					end
				end
			end
			S_ACTIVE: begin
				// Core running, sub-mode as selected. [R02]
				st_next.out.submode = app_cfg.submode;
				// Config only while the core runs; kept otherwise. [R15]
				if (app_cfg.cfg_wr) begin
					st_next.mode = app_cfg.mode; // [R07]
					st_next.wake_mask = app_cfg.wake_mask;
					st_next.wake_time = app_cfg.wake_time;
				end
				// Attach request holds until the network agrees. [R10]
				if (net.attach_done) begin
					st_next.out.attach_req = 1'b0;
				end
				// Inactivity counts from the last pending data. [R14]
				if (net.data_pending) begin
					st_next.cnt = 24'h000000;
				end else if (st_reg.cnt < inactive_cycles) begin
					st_next.cnt = st_reg.cnt + 24'h000001;
				end
				if (app_cfg.deep_enable && use_alone) begin
					st_next.net_mode = 1'b0;
					st_next.cnt = 24'h000000;
					st_next.out.attach_req = 1'b0;
					if (net.attached) begin
						st_next.fsm = S_DETACH; // [R09]
						st_next.out.detach_req = 1'b1;
					end else begin
						st_next.fsm = S_DEEP; // [R05]
						st_next.out.state = PWR_DEEP;
						st_next.out.app_core_on = 1'b0;
						st_next.out.modem_on = 1'b0;
					end
				end else if ((app_cfg.deep_enable && use_net)
					|| (st_reg.net_mode && !net.data_pending
					&& st_reg.cnt >= inactive_cycles)) begin
					// Context kept, enter for negotiated period. [R12]
					st_next.net_mode = 1'b1;
					st_next.cnt = 24'h000000;
					st_next.fsm = S_DEEP; // [R05] [R14]
					st_next.out.state = PWR_DEEP;
					st_next.out.app_core_on = 1'b0;
					st_next.out.modem_on = 1'b0;
				end else if (sleep_ok && !wake_hit) begin
					st_next.fsm = S_SLEEP; // [R01] [R04]
					st_next.out.state = PWR_SLEEP;
				end
			end
			S_SLEEP: begin
				// Core suspended, modem stays powered. [R03]
				if (!sleep_ok || wake_hit) begin
					st_next.fsm = S_ACTIVE; // [R03]
					st_next.out.state = PWR_ACTIVE;
				end
			end
			S_DETACH: begin
				// Leave the network before powering down. [R09]
				if (net.detach_done || !net.attached) begin
					st_next.out.detach_req = 1'b0;
					st_next.fsm = S_DEEP;
					st_next.out.state = PWR_DEEP;
					st_next.out.app_core_on = 1'b0;
					st_next.out.modem_on = 1'b0;
				end
			end
			S_DEEP: begin
				// Stay without limit unless a source fires. [R08]
				st_next.out.app_core_on = 1'b0;
				st_next.out.modem_on = 1'b0;
				if (st_reg.net_mode || st_reg.wake_time != 24'h000000) begin
					st_next.cnt = st_reg.cnt + 24'h000001;
				end
				if (wake_hit || (st_reg.net_mode
					&& st_reg.cnt >= deep_limit - 24'h000001)
					|| (!st_reg.net_mode && st_reg.wake_time != 24'h000000
					&& st_reg.cnt >= st_reg.wake_time - 24'h000001)) begin
					st_next.fsm = S_BOOT; // [R06]
					st_next.out.state = PWR_ACTIVE;
					st_next.cnt = 24'h000000;
				end
			end
			S_BOOT: begin
				// Full reboot; further wakes are ignored. [R06] [R18]
				st_next.out.state = PWR_ACTIVE;
				st_next.out.app_core_on = 1'b0;
				st_next.out.modem_on = 1'b1;
				st_next.cnt = st_reg.cnt + 24'h000001;
				if (st_reg.cnt >= boot_lim - 24'h000001) begin
					st_next.fsm = S_ACTIVE;
					st_next.cnt = 24'h000000;
					st_next.out.app_core_on = 1'b1;
					st_next.out.rebooted = 1'b1;
					st_next.out.submode = app_cfg.submode;
					st_next.out.tau_send = st_reg.net_mode; // [R13]
					st_next.out.attach_req = !st_reg.net_mode; // [R10]
				end
			end
			default: begin
				st_next.fsm = S_OFF;
			end
		endcase
		// Shows that the network cycle owns the deepest-state timing. [R12]
		st_next.out.net_saving = st_next.net_mode;
	end

	// State register; Off with empty config after reset.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '{fsm: S_OFF, pon_s1: 1'b1, pon_s2: 1'b1,
				trdy_s1: 1'b0, trdy_s2: 1'b0, wake_s1: '0,
				wake_s2: '0, mode: MODE_STANDALONE,
				wake_mask: WAKE_MASK_RST, wake_time: 24'h000000,
				net_mode: 1'b0, cnt: 24'h000000,
				out: '{state: PWR_OFF, submode: SUB_FULL,
				default: 1'b0}};
		end else begin
			st_reg <= st_next;
		end
	end

	assign status = st_reg.out;
endmodule : module_power_state_manager

// ==== shared/pwr_pkg.sv ====
/*
 * Shared types and constants of the module power state manager.
 * Assumes a 20 MHz core clock and that all timing inputs are cycle counts.
 */
package pwr_pkg;
	// Core clock rate in hertz.
	localparam int unsigned CLK_HZ = 20000000;
	// Boot time of both processors after a deepest-state wake, in us.
	localparam int unsigned BOOT_TIME_US = 50;
	// Cycles of the boot wait; the clock rate in MHz is rounded down.
	localparam int unsigned BOOT_CYC = (BOOT_TIME_US * (CLK_HZ / 1000000));
	// Extra guard between wake timer and network update timer, in cycles.
	localparam logic [23:0] TAU_GUARD_CYC = 24'h000100;
	// Cycles the pin synchronisers need before the strap is valid.
	localparam logic [23:0] SETTLE_CYC = 24'h000003;
	// Number of wake source pins.
	localparam int unsigned WAKE_W = 4;
	// Reset value of the wake source mask.
	localparam logic [3:0] WAKE_MASK_RST = 4'h0;

	// Internal sequencer states, one-hot.
	typedef enum logic [5:0] {
		S_OFF    = 6'h01,
		S_ACTIVE = 6'h02,
		S_SLEEP  = 6'h04,
		S_DETACH = 6'h08,
		S_DEEP   = 6'h10,
		S_BOOT   = 6'h20
	} fsm_t;

	// The four externally visible power states.
	typedef enum logic [1:0] {
		PWR_OFF    = 2'h0,
		PWR_ACTIVE = 2'h1,
		PWR_SLEEP  = 2'h2,
		PWR_DEEP   = 2'h3
	} power_state_t;

	// Deepest-state entry selection.
	typedef enum logic [1:0] {
		MODE_STANDALONE = 2'h0,
		MODE_NETWORK    = 2'h1,
		MODE_NET_FALLBK = 2'h2
	} deep_mode_t;

	// Active sub-modes.
	typedef enum logic [1:0] {
		SUB_FULL     = 2'h0,
		SUB_IDLE     = 2'h1,
		SUB_AIRPLANE = 2'h2,
		SUB_EXT_DRX  = 2'h3
	} submode_t;

	// Conditions that gate Sleep entry, all on the core clock.
	typedef struct packed {
		logic usb_attached;
		logic usb_suspended;
		logic wake_lock_held;
		logic gpio_hold;
		logic ctrl_hold;
	} sleep_cond_t;

	// Cellular network side status.
	typedef struct packed {
		logic attached;
		logic saving_supported;
		logic detach_done;
		logic attach_done;
		logic data_pending;
	} net_status_t;

	// Application configuration port.
	typedef struct packed {
		logic        cfg_wr;
		deep_mode_t  mode;
		logic [3:0]  wake_mask;
		logic [23:0] wake_time;
		logic        deep_enable;
		submode_t    submode;
	} app_cfg_t;

	// Outputs of the block.
	typedef struct packed {
		power_state_t state;
		submode_t     submode;
		logic         app_core_on;
		logic         modem_on;
		logic         detach_req;
		logic         attach_req;
		logic         tau_send;
		logic         rebooted;
		logic         net_saving;
	} pwr_status_t;
endpackage : pwr_pkg

// ==== tb/pwr_sva.sv ====
/* Checker of the power state manager's ports.
 * Assumes a bind onto module_power_state_manager. */
`timescale 1ns/1ps
module pwr_sva
	import pwr_pkg::*;
(
	// Watched ports.
	input wire logic        core_clk,
	input wire logic        arst_n,
	input wire sleep_cond_t sleep_cond,
	input wire net_status_t net,
	input wire pwr_status_t status
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	AST_DEEP_OFF: assert property (
		status.state == PWR_DEEP |-> !status.app_core_on && !status.modem_on)
		else $error("core on in deep");
	AST_DEEP_EXIT: assert property (
		$past(status.state) == PWR_DEEP && status.state != PWR_DEEP
		|-> status.state == PWR_ACTIVE && !status.app_core_on)
		else $error("deep exit skips boot");
	AST_ONE_BOOT: assert property (
		status.rebooted |=> !status.rebooted [*8])
		else $error("double reboot");
	AST_BOOT_UP: assert property (
		status.rebooted |-> status.app_core_on && status.state == PWR_ACTIVE)
		else $error("boot end not active");
	AST_TAU: assert property (
		status.tau_send |-> status.rebooted && !status.attach_req)
		else $error("update off boot end");
	AST_DETACH: assert property (
		status.detach_req && net.attached && !net.detach_done
		|=> status.state != PWR_DEEP && status.detach_req)
		else $error("deep before detach");
	AST_SLEEP_EXIT: assert property (
		status.state == PWR_SLEEP && sleep_cond.wake_lock_held
		|=> status.state == PWR_ACTIVE)
		else $error("sleep held by lock");
	AST_PENDING: assert property (
		status.state == PWR_ACTIVE && net.data_pending
		|=> status.state != PWR_DEEP)
		else $error("deep with data pending");
	AST_POWERUP: assert property (
		$past(status.state) == PWR_OFF && status.state != PWR_OFF
		|-> status.state == PWR_DEEP || !status.app_core_on)
		else $error("bad power up");
endmodule : pwr_sva
bind module_power_state_manager pwr_sva i_pwr_sva (.core_clk(core_clk),
	.arst_n(arst_n), .sleep_cond(sleep_cond), .net(net), .status(status));

// ==== tb/pwr_partner.sv ====
/* Behavioural cellular network answering attach and detach requests.
 * Assumes the block's status struct on the same core clock. */
`timescale 1ns/1ps
module pwr_partner
	import pwr_pkg::*;
(
	// Clock, reset and block status.
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire pwr_status_t status,
	// Bench controls and network answer.
	input  wire logic        sup,
	input  wire logic        pend,
	output net_status_t      net
);
	logic [1:0] dly; // Answer delay, so the block must wait.
	// This model owns no general-purpose pins, so none is driven.
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			net <= '{attached: 1'b1, default: 1'b0};
			dly <= 2'h0;
		end else begin
			net.saving_supported <= sup;
			net.data_pending <= pend;
			dly <= (status.detach_req | status.attach_req) ? dly + 2'h1 : 2'h0;
			// Requests are answered after four cycles.
			net.detach_done <= status.detach_req && dly == 2'h3;
			net.attach_done <= status.attach_req && dly == 2'h3;
			if (net.detach_done)
				net.attached <= 1'b0;
			if (net.attach_done)
				net.attached <= 1'b1;
		end
	end
endmodule : pwr_partner

// ==== tb/tb_top.sv ====
/* Self-checking bench of the power state manager.
 * Assumes the network partner model and a short boot. */
`timescale 1ns/1ps
module tb_top;
	import pwr_pkg::*;
	localparam int BC = 8; // Short boot keeps the run brief.
	logic core_clk, arst_n, power_on_req_n, term_ready, sup, pend;
	logic [3:0]  wake_pins;
	logic [23:0] tau_cycles, inactive_cycles;
	app_cfg_t    app_cfg;
	sleep_cond_t sleep_cond;
	net_status_t net;
	pwr_status_t status;
	int errors, comparisons, boots;
	module_power_state_manager #(.BOOT_CYCLES(BC))
		i_module_power_state_manager (.core_clk, .arst_n, .power_on_req_n,
		.term_ready, .wake_pins, .app_cfg, .sleep_cond, .net, .tau_cycles,
		.inactive_cycles, .status);
	pwr_partner i_pwr_partner (.core_clk, .arst_n, .status, .sup, .pend,
		.net);
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
		boots <= boots + int'(status.rebooted === 1'b1);
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask : tick
	task automatic wait_st(input power_state_t s, input int n);
		for (int i = 0; i < n && status.state !== s; i++)
			tick();
		check(status.state, s);
	endtask : wait_st
	task automatic wait_boot(input int n);
		for (int i = 0; i < n && status.rebooted !== 1'b1; i++)
			tick();
		check(status.rebooted, 1'b1);
	endtask : wait_boot
	task automatic do_reset(input logic strap);
		@(posedge core_clk);
		arst_n <= 1'b0;
		power_on_req_n <= strap;
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
	endtask : do_reset
	// Store a mode and wake timer, then ask for the deepest state.
	task automatic cfg(input deep_mode_t m, input logic [23:0] t);
		@(posedge core_clk);
		app_cfg.cfg_wr <= 1'b1;
		app_cfg.mode <= m;
		app_cfg.wake_time <= t;
		@(posedge core_clk);
		app_cfg.cfg_wr <= 1'b0;
		app_cfg.deep_enable <= 1'b1;
		@(posedge core_clk);
		app_cfg.deep_enable <= 1'b0;
		#1;
	endtask : cfg
	task automatic pulse(input logic [3:0] p);
		@(posedge core_clk);
		wake_pins <= p;
		@(posedge core_clk);
		wake_pins <= 4'h0;
		#1;
	endtask : pulse
	task automatic t_power();
		do_reset(1'b1);
		wait_st(PWR_DEEP, 10);
		repeat (40) tick();
		check(status.state, PWR_DEEP);
		do_reset(1'b0);
		wait_boot(30);
		check(status.app_core_on, 1'b1);
	endtask : t_power
	task automatic t_submode();
		for (int s = 0; s < 4; s++) begin
			@(posedge core_clk);
			app_cfg.submode <= submode_t'(s);
			repeat (2) tick();
			check(status.submode, s);
		end
	endtask : t_submode
	task automatic t_sleep();
		@(posedge core_clk);
		sleep_cond.wake_lock_held <= 1'b0;
		wait_st(PWR_SLEEP, 6);
		check(status.modem_on, 1'b1);
		@(posedge core_clk);
		term_ready <= 1'b1;
		wait_st(PWR_ACTIVE, 6);
		@(posedge core_clk);
		term_ready <= 1'b0;
		wait_st(PWR_SLEEP, 8);
		@(posedge core_clk);
		sleep_cond.wake_lock_held <= 1'b1;
		tick();
		check(status.state, PWR_ACTIVE);
	endtask : t_sleep
	task automatic t_alone();
		int b;
		cfg(MODE_STANDALONE, 24'h000000);
		wait_st(PWR_DEEP, 20);
		check(net.attached, 1'b0);
		check(status.modem_on, 1'b0);
		check(status.net_saving, 1'b0);
		repeat (40) tick();
		b = boots;
		pulse(4'h1);
		pulse(4'h2);
		wait_boot(30);
		check(status.attach_req, 1'b1);
		check(status.modem_on, 1'b1);
		repeat (20) tick();
		check(boots - b, 1);
	endtask : t_alone
	task automatic t_net();
		sup <= 1'b1;
		cfg(MODE_NETWORK, 24'h000000);
		wait_st(PWR_DEEP, 4);
		check(status.net_saving, 1'b1);
		wait_boot(260);
		check(status.tau_send, 1'b1);
		wait_st(PWR_DEEP, 30);
		pend <= 1'b1;
		pulse(4'h2);
		wait_boot(30);
		check(status.tau_send, 1'b1);
		repeat (30) tick();
		check(status.state, PWR_ACTIVE);
		sup <= 1'b0;
		cfg(MODE_NETWORK, 24'h000000);
		repeat (5) tick();
		check(status.state, PWR_ACTIVE);
		pend <= 1'b0;
		cfg(MODE_NET_FALLBK, 24'h000020);
		wait_st(PWR_DEEP, 20);
		check(net.attached, 1'b0);
		check(status.net_saving, 1'b0);
		wait_boot(60);
		check(status.attach_req, 1'b1);
	endtask : t_net
	task automatic stop_test();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	initial begin
		{term_ready, wake_pins, sup, pend, boots} = '0;
		arst_n = 1'b0;
		power_on_req_n = 1'b1;
		app_cfg = '0;
		app_cfg.wake_mask = 4'h3;
		sleep_cond = '0;
		sleep_cond.wake_lock_held = 1'b1;
		tau_cycles = 24'h0001D0;
		inactive_cycles = 24'h000010;
		t_power();
		t_submode();
		t_sleep();
		t_alone();
		t_net();
		stop_test();
	end
	initial begin
		#200000;
		errors++;
		stop_test();
	end
endmodule : tb_top
